// ===== adc_port_map.svh
/*
  constants of the converter output port: widths, latency, fifo depth, timing.
  assumes inclusion by bare name from the package and the top module.
*/
// Function
// - new result every sample clock, out 2.5 clock cycles after its sample edge
// - data pins driven only while active-low output enable is low, else floating
// - msb invert high flips the top bit for two's complement, low gives binary
// - sample strobe output is a delayed copy of the sample clock
// - result is a twelve-bit word, bit eleven msb, bit zero lsb
// - unconnected output enable or msb invert reads as low
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH
`define RESULT_WIDTH      12
`define RESULT_MSB        11
`define LATENCY_HALVES    5
`define FIFO_DEPTH        32
`define FIFO_AW           5
`define SAMPLE_MAX_MHZ    2
`define REF_CLK_MHZ       250
`define MIN_HALF_CYCLES   ((`REF_CLK_MHZ + 2 * `SAMPLE_MAX_MHZ - 1) / (2 * `SAMPLE_MAX_MHZ))
`endif

// ===== adc_port_pkg.sv
/*
  types of the converter output port.
  assumes adc_port_map.svh is reachable by bare name.
*/
`default_nettype none
`include "adc_port_map.svh"
package adc_port_pkg;
  typedef logic [`RESULT_WIDTH-1:0] result_t;
  // data pin bundle: values and active-low enables per bit
  typedef struct packed {
    result_t data;
    result_t oe_n;
  } pins_t;
endpackage : adc_port_pkg
`default_nettype wire

// ===== adc_parallel_output_port.sv
/*
  output side of a 12-bit pipelined converter: result stream through a fifo,
  a latency pipe on sample clock edges, coding select, three-state data port.
  a word popped at a filtered sample clock rise moves one stage on each of the
  next two rises and reaches the pins at the fall after the second one: two and
  a half sample periods after its sampling edge. no high impedance value is
  made here; result_oe_n tells the pad ring which bits to release.
  assumes sample_clk arrives from a pin asynchronous to ref_clk, well below
  half the ref_clk rate; conversion words arrive on the ref_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_map.svh"

// small fifo with valid/ready on both sides
module result_fifo #(
  parameter int WIDTH = `RESULT_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW    = `FIFO_AW
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          rdy;
  } fifo_st_t;
  fifo_st_t         st_ff;
  fifo_st_t         nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = st_ff.rdy;
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = mem[st_ff.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    nxt_st = st_ff;
    if (push) nxt_st.wr = st_ff.wr + 1'b1;
    if (pop) nxt_st.rd = st_ff.rd + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // ready is registered so the fill side sees a flop, not a compare
    nxt_st.rdy = (nxt_st.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // storage has no reset
  always_ff @(posedge clk) begin
    if (push) mem[st_ff.wr] <= in_data;
  end

  // count never passes the depth
  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  // a full fifo refuses further words
  a_fifo_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff.cnt == (AW+1)'(DEPTH)) |-> !in_ready)
    else $error("full fifo still ready");
endmodule : result_fifo

module adc_parallel_output_port (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // sample clock and pin controls from outside
  input  wire logic                sample_clk,
  input  wire logic                output_enable_n,
  input  wire logic                msb_invert_select,
  // conversion words from the core
  input  wire logic                conv_valid,
  output logic                     conv_ready,
  input  wire adc_port_pkg::result_t conv_data,
  // three-state data port
  output adc_port_pkg::result_t    result_out,
  output adc_port_pkg::result_t    result_oe_n,
  // sample instant strobe
  output logic                     sample_strobe
);
  typedef struct packed {
    logic [1:0]            rst_sync;
    logic [2:0]            clk_sync;
    logic [2:0]            oe_sync;
    logic [2:0]            inv_sync;
    logic                  clk_lvl;
    logic                  oe_lvl;
    logic                  inv_lvl;
    logic                  strobe;
    logic                  take;
    adc_port_pkg::result_t pipe0;
    adc_port_pkg::result_t pipe1;
    adc_port_pkg::result_t pipe2;
    adc_port_pkg::pins_t   pins;
  } top_st_t;
  top_st_t               st_ff;
  top_st_t               nxt_st;
  logic                  rst_n;
  logic                  q_valid;
  adc_port_pkg::result_t q_data;
  logic                  rise;
  logic                  fall;
  adc_port_pkg::result_t coded;

  assign rst_n = st_ff.rst_sync[1];

  result_fifo #(
    .WIDTH (`RESULT_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (conv_data),
    .out_valid (q_valid),
    .out_ready (st_ff.take),
    .out_data  (q_data)
  );

  // edges of sample clock once stages two and three agree
  assign rise = (st_ff.clk_sync[2:1] == 2'b11) && !st_ff.clk_lvl;
  assign fall = (st_ff.clk_sync[2:1] == 2'b00) && st_ff.clk_lvl;

  // coding select on the top bit
  always_comb begin
    coded = st_ff.pipe2;
    coded[`RESULT_MSB] = st_ff.pipe2[`RESULT_MSB] ^ st_ff.inv_lvl;
  end

  // next state: input filters, edge tracking, latency pipe, pins
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
    nxt_st.clk_sync = {st_ff.clk_sync[1:0], sample_clk};
    nxt_st.oe_sync  = {st_ff.oe_sync[1:0], output_enable_n};
    nxt_st.inv_sync = {st_ff.inv_sync[1:0], msb_invert_select};
    if (rise || fall) nxt_st.clk_lvl = !st_ff.clk_lvl;
    if (st_ff.oe_sync[2] == st_ff.oe_sync[1]) nxt_st.oe_lvl = st_ff.oe_sync[2];
    if (st_ff.inv_sync[2] == st_ff.inv_sync[1]) nxt_st.inv_lvl = st_ff.inv_sync[2];
    nxt_st.strobe = nxt_st.clk_lvl;
    nxt_st.take = 1'b0;
    // sample at rise 0, one stage per rise, pins at the fall after rise 2:
    // five half cycles from the sampling edge; shifting on falls as well
    // would land the word a whole sample period early
    if (rise) begin
      nxt_st.take  = q_valid;
      nxt_st.pipe0 = q_valid ? q_data : st_ff.pipe0;
      nxt_st.pipe1 = st_ff.pipe0;
      nxt_st.pipe2 = st_ff.pipe1;
    end
    if (fall) nxt_st.pins.data = coded;
    nxt_st.pins.oe_n = {`RESULT_WIDTH{st_ff.oe_lvl}};
  end

  // one register for the whole state, cleared by the pin reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) st_ff <= '0; // zero means enabled, binary
    else st_ff <= nxt_st;
  end

  assign result_out    = st_ff.pins.data;
  assign result_oe_n   = st_ff.pins.oe_n;
  assign sample_strobe = st_ff.strobe;

  // port enable follows the filtered enable level
  a_port_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(st_ff.oe_lvl) |=> (result_oe_n == {`RESULT_WIDTH{$past(st_ff.oe_lvl)}}))
    else $error("port enable does not follow output enable");
  // strobe tracks the filtered sample clock
  a_strobe_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise |=> sample_strobe)
    else $error("strobe missed sample edge");
  // top bit flips with invert select
  a_msb_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fall |=> (result_out[`RESULT_MSB] == ($past(st_ff.pipe2[`RESULT_MSB]) ^ $past(st_ff.inv_lvl))))
    else $error("msb coding wrong");
  // lower bits pass unchanged
  a_low_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fall |=> (result_out[`RESULT_MSB-1:0] == $past(st_ff.pipe2[`RESULT_MSB-1:0])))
    else $error("low bits altered");
  // output changes only after a falling sample edge
  a_update_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(result_out) |-> $past(fall))
    else $error("output changed off edge");
  // strobe drops with the filtered sample clock
  a_strobe_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fall |=> !sample_strobe)
    else $error("strobe missed falling edge");
  // a word leaves the fifo only after a rise
  a_take_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.take |-> $past(rise))
    else $error("fifo popped off a rise");
  // every rise with a word waiting pops it
  a_take_pop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rise && q_valid) |=> st_ff.take)
    else $error("waiting word not popped");
  // each rise moves the pipe one stage
  a_pipe_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise |=> (st_ff.pipe1 == $past(st_ff.pipe0)) && (st_ff.pipe2 == $past(st_ff.pipe1)))
    else $error("pipe did not step");
  // the pipe holds between rises
  a_pipe_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rise |=> $stable(st_ff.pipe0) && $stable(st_ff.pipe1) && $stable(st_ff.pipe2))
    else $error("pipe moved off a rise");
endmodule : adc_parallel_output_port
`default_nettype wire

// ===== capture_model.sv
/*
  capture model: registers the data port once per sample clock rise.
  assumes the port has settled well before each sample clock rise.
*/
`timescale 1ns/10ps
`default_nettype none
module capture_model (
  // port side
  input  wire logic                  sample_clk,
  input  wire adc_port_pkg::result_t pin_data,
  input  wire adc_port_pkg::result_t pin_oe_n,
  // captured word
  output adc_port_pkg::result_t      cap_data
);
  adc_port_pkg::result_t last = '0;
  // floating bits show the inverse of their last level
  wire adc_port_pkg::result_t bus = (pin_data & ~pin_oe_n) | (~last & pin_oe_n);
  // one word per sample period
  always @(posedge sample_clk) begin
    cap_data <= bus;
    last     <= bus;
  end
endmodule : capture_model
`default_nettype wire

// ===== tb_adc_parallel_output_port.sv
/*
  testbench: coding rows, enable, fifo fill and drain, latency and strobe.
  assumes the design package is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_adc_parallel_output_port;
  typedef struct packed {logic inv; adc_port_pkg::result_t w, e;} row_t;
  logic ref_clk = 1'b0, resetn = 1'b0, sample_clk = 1'b0, run = 1'b0, oe_n = 1'b0, inv = 1'b0;
  logic cv = 1'b0, ok = 1'b0;
  logic conv_ready, sample_strobe;
  adc_port_pkg::result_t cd = '0, r_out, r_oe_n, cap, c0;
  int err_count = 0, tests_run = 0, cycles = 0;
  row_t rows[6] = '{'{1'b0, 12'h000, 12'h000}, '{1'b0, 12'hFFF, 12'hFFF},
                    '{1'b1, 12'h000, 12'h800}, '{1'b1, 12'hFFF, 12'h7FF},
                    '{1'b0, 12'h801, 12'h801}, '{1'b1, 12'hA5C, 12'h25C}};
  adc_parallel_output_port DUT (.ref_clk(ref_clk), .resetn(resetn), .sample_clk(sample_clk),
    .output_enable_n(oe_n), .msb_invert_select(inv), .conv_valid(cv), .conv_ready(conv_ready),
    .conv_data(cd), .result_out(r_out), .result_oe_n(r_oe_n), .sample_strobe(sample_strobe));
  capture_model partner (.sample_clk(sample_clk), .pin_data(r_out), .pin_oe_n(r_oe_n),
    .cap_data(cap));
  // clocks: sample period 512 ns, below the 2 MHz ceiling
  initial forever #2 ref_clk = ~ref_clk;
  initial begin #3; forever #256 sample_clk = run ? ~sample_clk : 1'b0; end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin err_count++; test_done; end
  end
  task test_done;
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // valid stays up after the accepting edge; the caller lowers it
  task push(input adc_port_pkg::result_t w);
    cd = w;
    cv = 1'b1;
    ok = 1'b0;
    while (!ok) begin
      ok = (conv_ready === 1'b1);
      @(posedge ref_clk);
      #1;
    end
  endtask : push
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 `CHK(r_oe_n, 12'h000)
    @(posedge ref_clk);
    #1 resetn = 1'b1;
    run = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    // coding rows, one word in flight at a time
    foreach (rows[i]) begin
      inv = rows[i].inv;
      @(negedge sample_clk);
      @(posedge ref_clk);
      #1 push(rows[i].w);
      cv = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 `CHK(sample_strobe, 1'b0)
      repeat (4) @(posedge sample_clk);
      repeat (6) @(posedge ref_clk);
      #1 `CHK(cap, rows[i].e)
      `CHK(sample_strobe, 1'b1)
    end
    inv = 1'b0;
    oe_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 `CHK(r_oe_n, 12'hFFF)
    // released pins read back as the inverse of the last capture
    @(posedge sample_clk);
    #1 c0 = cap;
    @(posedge sample_clk);
    #1 `CHK(cap, ~c0)
    oe_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 `CHK(r_oe_n, 12'h000)
    // fill with the sample clock stopped, then one refused word
    run = 1'b0;
    repeat (300) @(posedge ref_clk);
    #1;
    for (int k = 0; k < 32; k++) push(12'(12'h100 + k));
    `CHK(conv_ready, 1'b0)
    cd = 12'hEEE;
    @(posedge ref_clk);
    #1 cv = 1'b0;
    // drain: the rise j shows the word popped at rise j-3, or the last word once the fifo is empty
    run = 1'b1;
    for (int j = 0; j < 36; j++) begin
      @(posedge sample_clk);
      #1;
      if (j >= 3) `CHK(cap, 12'h100 + ((j - 3 > 31) ? 31 : j - 3))
    end
    `CHK(cap[11], 1'b0)
    test_done;
  end
endmodule : tb_adc_parallel_output_port
`default_nettype wire
